// >>> rtl/ucs_map.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  serial control and status block.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
`ifndef UCS_MAP_VH
`define UCS_MAP_VH

// Register byte offsets, one aligned word each.
`define UCS_OFS_CTRL_ONE 8'h00
`define UCS_OFS_CTRL_TWO 8'h04
`define UCS_OFS_STATUS_ONE 8'h08
`define UCS_OFS_DATA 8'h0C
`define UCS_OFS_BIT_DIV 8'h10

// First control register fields.
`define UCS_C1_LOOP 7
`define UCS_C1_RX_SRC 5
`define UCS_C1_WAKE 3
`define UCS_C1_DIR 1
`define UCS_C1_LONG_BRK 0

// Second control register fields.
`define UCS_C2_TX_EMPTY_IE 7
`define UCS_C2_TX_DONE_IE 6
`define UCS_C2_RX_FULL_IE 5
`define UCS_C2_QUIET_IE 4
`define UCS_C2_TX_ON 3
`define UCS_C2_RX_ON 2
`define UCS_C2_RX_SLEEP 1
`define UCS_C2_BRK 0

// First status register fields.
`define UCS_S1_TX_EMPTY 7
`define UCS_S1_TX_DONE 6
`define UCS_S1_RX_FULL 5
`define UCS_S1_QUIET 4
`define UCS_S1_OVERRUN 3

// Reset values.
`define UCS_RST_CTRL 8'h00
`define UCS_RST_BIT_DIV 16'h00AD

// Character lengths in bit times.
`define UCS_CHAR_BITS 4'hA
`define UCS_BRK_BITS 4'hA
`define UCS_LONG_BRK_BITS 4'hD
`endif

// >>> rtl/ucs_core.v
/*
  Serial control and status block: control registers, status flags, a
  buffered transmitter with queued idle and break, a receiver with standby
  and wakeup, pin ownership and one interrupt request.
  Assumes an Avalon-MM master on clk_sys_in and serial pins that are
  asynchronous to it; pin inputs pass two flip-flops.
*/
// Design decisions made here: the Avalon-MM register port and the register offsets.
// Notes on behaviour
// - Empty-buffer flag with its enable requests interrupt.
// - Done flag with its enable requests interrupt.
// - Receive-full flag with its enable requests interrupt.
// - Quiet-line flag with its enable requests interrupt.
// - Transmitter runs and owns output when on or still finishing queued work.
// - Single-wire mode: direction bit steers shared line.
// - Off-then-on during sending queues one idle.
// - After off, keep pin until queued work ends.
// - Receive pin released when off or looped.
// - Writing sleep puts receiver in standby.
// - Wake on quiet line or address mark.
// - Software sets sleep; hardware clears it on wake.
// - Setting then clearing break queues one break.
// - Break held keeps queuing ten or thirteen zeros.
// - A second break may follow; both accepted.
// - Second control register accessible at any time.
// - Status read-only; cleared by access sequences.
// - Empty flag: set on move, cleared read-write.
// - Done flag: set when idle, cleared by sequence.
// - Full flag: set on receive, cleared read-read.
// - Quiet flag set once after a character.
`include "ucs_map.vh"

module ucs_core (
  // Clock and reset.
  input wire clk_sys_in,
  input wire nrst_in,
  // Avalon-MM register slave.
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Transmit pin, split into its three signals.
  input wire serial_out_pin_in,
  output reg serial_out_pin_out,
  output wire serial_out_pin_oe_out,
  // Receive pin and its ownership.
  input wire serial_in_pin_in,
  output wire serial_in_pin_owned_out,
  // Interrupt request.
  output reg irq_out
);

  localparam ST_IDLE = 4'h1;
  localparam ST_START = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_STOP = 4'h8;

  // Length of a break character for the chosen break length.
  function [3:0] brk_len;
    input long_sel;
    begin
      brk_len = long_sel ? `UCS_LONG_BRK_BITS : `UCS_BRK_BITS;
    end
  endfunction

  reg [7:0] ctrl_one;
  reg [7:0] ctrl_two;
  reg [15:0] bit_div;
  reg ack;
  reg tx_empty;
  reg tx_done;
  reg rx_full;
  reg quiet;
  reg overrun;
  reg [4:0] armed;
  reg [7:0] tx_buf;
  reg [9:0] tx_shift;
  reg [3:0] tx_left;
  reg tx_busy;
  reg idle_pend;
  reg brk_pend;
  reg tx_run;
  reg [15:0] tx_cnt;
  reg [7:0] rx_data;
  reg [1:0] rx_pin_sync;
  reg [1:0] tx_pin_sync;
  reg [3:0] rx_state;
  reg [15:0] rx_cnt;
  reg [2:0] rx_bit;
  reg [7:0] rx_shift;
  reg [15:0] q_cnt;
  reg [3:0] q_bits;
  reg q_armed;

  wire loop_sel = ctrl_one[`UCS_C1_LOOP];
  wire single_wire = loop_sel & ctrl_one[`UCS_C1_RX_SRC];
  wire tx_on = ctrl_two[`UCS_C2_TX_ON];
  wire rx_on = ctrl_two[`UCS_C2_RX_ON];
  wire rx_sleep = ctrl_two[`UCS_C2_RX_SLEEP];
  wire brk_bit = ctrl_two[`UCS_C2_BRK];
  wire acc = ack & (avs_read_in | avs_write_in);
  wire wr = ack & avs_write_in;
  wire rd = ack & avs_read_in;
  wire wr_c2 = wr & (avs_address_in == `UCS_OFS_CTRL_TWO);
  wire wr_data = wr & (avs_address_in == `UCS_OFS_DATA);
  wire rd_stat = rd & (avs_address_in == `UCS_OFS_STATUS_ONE);
  wire rd_data = rd & (avs_address_in == `UCS_OFS_DATA);
  wire [7:0] new_c2 = avs_writedata_in[7:0];
  wire tx_tick = (tx_cnt == 16'h0000) & (bit_div != 16'h0000);
  wire tx_load = tx_tick & ~tx_busy;
  wire tx_go = tx_on | tx_run;
  wire start_brk = tx_load & tx_go & (brk_pend | brk_bit);
  wire start_idle = tx_load & tx_go & ~start_brk & idle_pend;
  wire start_data = tx_load & tx_go & ~start_brk & ~start_idle & ~tx_empty;
  wire tx_work = tx_busy | idle_pend | brk_pend | brk_bit | ~tx_empty;
  wire tx_owned = tx_go | tx_busy | idle_pend | brk_pend;
  wire rx_line = loop_sel ? (single_wire ? tx_pin_sync[1] : serial_out_pin_out)
                          : rx_pin_sync[1];
  wire rx_half = (rx_cnt == {1'b0, bit_div[15:1]});
  wire rx_end = (rx_cnt == bit_div);
  wire rx_char = (rx_state == ST_STOP) & rx_half;
  wire rx_enabled = rx_on;
  wire quiet_hit;
  wire wake_idle = rx_sleep & ~ctrl_one[`UCS_C1_WAKE] & quiet_hit;
  wire wake_mark = rx_sleep & ctrl_one[`UCS_C1_WAKE] & rx_char & rx_shift[7];

  // Pin ownership; in single-wire mode the direction bit decides who drives.
  assign serial_out_pin_oe_out = tx_owned & (~single_wire | ctrl_one[`UCS_C1_DIR]);
  assign serial_in_pin_owned_out = rx_on & ~loop_sel;
  assign quiet_hit = q_armed & (q_bits == `UCS_CHAR_BITS);

  // Bus answers one cycle after the request arrives, so writes and side
  // effects happen once, on the edge where waitrequest is seen low.
  assign avs_waitrequest_out = ~ack;

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
      if (avs_read_in & ~ack) begin
        case (avs_address_in)
          `UCS_OFS_CTRL_ONE: avs_readdata_out <= {24'h000000, ctrl_one};
          `UCS_OFS_CTRL_TWO: avs_readdata_out <= {24'h000000, ctrl_two};
          `UCS_OFS_STATUS_ONE: avs_readdata_out <= {24'h000000, tx_empty, tx_done,
                                                   rx_full, quiet, overrun, 3'h0};
          `UCS_OFS_DATA: avs_readdata_out <= {24'h000000, rx_data};
          `UCS_OFS_BIT_DIV: avs_readdata_out <= {16'h0000, bit_div};
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers. Sleep is cleared by hardware on the wakeup event,
  // and that clear loses to a software write of one in the same cycle.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ctrl_one <= `UCS_RST_CTRL;
      ctrl_two <= `UCS_RST_CTRL;
      bit_div <= `UCS_RST_BIT_DIV;
    end else begin
      if (wr & (avs_address_in == `UCS_OFS_CTRL_ONE))
        ctrl_one <= avs_writedata_in[7:0];
      if (wr & (avs_address_in == `UCS_OFS_BIT_DIV))
        bit_div <= avs_writedata_in[15:0];
      if (wr_c2) begin
        ctrl_two <= new_c2;
      end else if (wake_idle | wake_mark) begin
        ctrl_two[`UCS_C2_RX_SLEEP] <= 1'b0;
      end
    end
  end

  // Status flags. Writes to the status word are ignored; each flag is
  // cleared only by a status read followed by the matching access.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tx_empty <= 1'b1;
      tx_done <= 1'b1;
      rx_full <= 1'b0;
      quiet <= 1'b0;
      overrun <= 1'b0;
      armed <= 5'h00;
    end else begin
      if (rd_stat)
        armed <= {tx_empty, tx_done, rx_full, quiet, overrun};
      else if (acc & ~rd_stat & (wr_data | rd_data))
        armed <= 5'h00;
      // Empty flag: the set from a buffer move wins over a clear.
      if (start_data)
        tx_empty <= 1'b1;
      else if (wr_data & armed[4])
        tx_empty <= 1'b0;
      if (~tx_work & tx_empty & ~wr_data)
        tx_done <= 1'b1;
      else if (armed[3] & (wr_data | (wr_c2 & ((new_c2[`UCS_C2_TX_ON] & ~tx_on) |
               new_c2[`UCS_C2_BRK]))))
        tx_done <= 1'b0;
      // Receive-full flag: the read-read clear wins over a new character in the same cycle.
      if (rx_char & rx_enabled & ~rx_sleep & ~rx_full)
        rx_full <= 1'b1;
      else if (rx_char & rx_enabled & wake_mark & ~rx_full)
        rx_full <= 1'b1;
      else if (rd_data & armed[2])
        rx_full <= 1'b0;
      if (rx_char & rx_enabled & ~rx_sleep & rx_full & ~(rd_data & armed[2]))
        overrun <= 1'b1;
      else if (rd_data & armed[0])
        overrun <= 1'b0;
      if (quiet_hit & rx_enabled & ~rx_sleep)
        quiet <= 1'b1;
      else if (rd_data & armed[1])
        quiet <= 1'b0;
    end
  end

  // Transmit buffer. A data write lands in the buffer; the move to the
  // shifter happens only at a bit boundary with the transmitter on or still running.
  always @(posedge clk_sys_in) begin
    if (!nrst_in)
      tx_buf <= 8'h00;
    else if (wr_data)
      tx_buf <= avs_writedata_in[7:0];
  end

  // Queued idle and queued break.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      idle_pend <= 1'b0;
      brk_pend <= 1'b0;
      tx_run <= 1'b0;
    end else begin
      // Stays running after switch-off until the queued work has gone out.
      tx_run <= tx_on | (tx_run & tx_work);
      // A rising enable while sending queues exactly one idle character.
      if (wr_c2 & new_c2[`UCS_C2_TX_ON] & ~tx_on & tx_busy)
        idle_pend <= 1'b1;
      else if (start_idle)
        idle_pend <= 1'b0;
      // Writing one latches a break request so a quick one-then-zero
      // still sends one; while the bit stays set, the bit itself keeps
      // queuing. The latch may already be spent when the bit is cleared,
      // so a second break can follow.
      if (wr_c2 & new_c2[`UCS_C2_BRK] & ~brk_bit)
        brk_pend <= 1'b1;
      else if (start_brk)
        brk_pend <= 1'b0;
    end
  end

  // Transmit shifter. Frames are start, eight data bits lsb first, stop.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tx_cnt <= 16'h0000;
      tx_shift <= 10'h3FF;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
      serial_out_pin_out <= 1'b1;
    end else begin
      if (tx_cnt == 16'h0000)
        tx_cnt <= bit_div;
      else
        tx_cnt <= tx_cnt - 16'h0001;
      if (start_brk) begin
        tx_shift <= 10'h000;
        tx_left <= brk_len(ctrl_one[`UCS_C1_LONG_BRK]) - 4'h1;
        tx_busy <= 1'b1;
        serial_out_pin_out <= 1'b0;
      end else if (start_idle) begin
        tx_shift <= 10'h3FF;
        tx_left <= `UCS_CHAR_BITS - 4'h1;
        tx_busy <= 1'b1;
        serial_out_pin_out <= 1'b1;
      end else if (start_data) begin
        tx_shift <= {1'b1, tx_buf, 1'b0};
        tx_left <= `UCS_CHAR_BITS - 4'h1;
        tx_busy <= 1'b1;
        serial_out_pin_out <= 1'b0;
      end else if (tx_tick & tx_busy) begin
        if (tx_left == 4'h0) begin
          tx_busy <= 1'b0;
          serial_out_pin_out <= 1'b1;
        end else begin
          tx_left <= tx_left - 4'h1;
          // Refill from the top bit, so a break stays low for its full length.
          tx_shift <= {tx_shift[9], tx_shift[9:1]};
          serial_out_pin_out <= tx_shift[1];
        end
      end
    end
  end

  // Pin synchronisers: the first stage feeds only the second.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_pin_sync <= 2'h3;
      tx_pin_sync <= 2'h3;
    end else begin
      rx_pin_sync <= {rx_pin_sync[0], serial_in_pin_in};
      tx_pin_sync <= {tx_pin_sync[0], serial_out_pin_in};
    end
  end

  // Receiver: finds the start edge, samples each bit at its middle.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_state <= ST_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
    end else begin
      case (rx_state)
        ST_IDLE: begin
          rx_cnt <= 16'h0000;
          if (rx_enabled & ~rx_line & (bit_div != 16'h0000))
            rx_state <= ST_START;
        end
        ST_START: begin
          rx_cnt <= rx_end ? 16'h0000 : rx_cnt + 16'h0001;
          if (rx_half & rx_line)
            rx_state <= ST_IDLE;
          else if (rx_end) begin
            rx_state <= ST_DATA;
            rx_bit <= 3'h0;
          end
        end
        ST_DATA: begin
          rx_cnt <= rx_end ? 16'h0000 : rx_cnt + 16'h0001;
          if (rx_half)
            rx_shift <= {rx_line, rx_shift[7:1]};
          if (rx_end) begin
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7)
              rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_half) begin
            rx_state <= ST_IDLE;
            // Standby drops characters unless an address mark wakes it.
            if (rx_enabled & (~rx_sleep | wake_mark) & ~rx_full)
              rx_data <= rx_shift;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Quiet-line detector: counts whole bit times of high line while the
  // receiver is idle. It arms on each received character and fires once.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      q_cnt <= 16'h0000;
      q_bits <= 4'h0;
      q_armed <= 1'b0;
    end else begin
      if (rx_char)
        q_armed <= 1'b1;
      else if (quiet_hit)
        q_armed <= 1'b0;
      if ((rx_state != ST_IDLE) | ~rx_line | quiet_hit) begin
        q_cnt <= 16'h0000;
        q_bits <= 4'h0;
      end else if (q_cnt == bit_div) begin
        q_cnt <= 16'h0000;
        if (q_bits != `UCS_CHAR_BITS)
          q_bits <= q_bits + 4'h1;
      end else begin
        q_cnt <= q_cnt + 16'h0001;
      end
    end
  end

  // One interrupt request, the OR of the four enabled flags.
  always @(posedge clk_sys_in) begin
    if (!nrst_in)
      irq_out <= 1'b0;
    else
      irq_out <= (ctrl_two[`UCS_C2_TX_EMPTY_IE] & tx_empty) |
                 (ctrl_two[`UCS_C2_TX_DONE_IE] & tx_done) |
                 (ctrl_two[`UCS_C2_RX_FULL_IE] & rx_full) |
                 (ctrl_two[`UCS_C2_QUIET_IE] & quiet);
  end

endmodule // ucs_core

// >>> tb/ucs_core_properties.sv
/* Port-level checks for the serial control block, bound to ucs_core.
   Assumes the one-wait-state bus answer and registered pin controls. */
`include "ucs_map.vh"
module ucs_props (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire serial_out_pin_in,
  input wire serial_out_pin_out,
  input wire serial_out_pin_oe_out,
  input wire serial_in_pin_in,
  input wire serial_in_pin_owned_out,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ie_h;
  wire acc_w = avs_write_in && !avs_waitrequest_out;
  // Mirror of the enables, since the mask is only visible through the bus.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) ie_h <= 4'h0;
    else if (acc_w && avs_address_in == `UCS_OFS_CTRL_TWO) ie_h <= avs_writedata_in[7:4];
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  wait_answer_a: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  idle_wait_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("answer without request");
  read_hold_a: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved");
  rx_own_write_a: assert property ($changed(serial_in_pin_owned_out) |-> $past(acc_w))
    else $error("receive pin owner changed alone");
  tx_own_write_a: assert property ($rose(serial_out_pin_oe_out) |-> $past(acc_w))
    else $error("transmit pin taken alone");
  release_high_a: assert property ($fell(serial_out_pin_oe_out) && !$past(avs_write_in)
    |-> serial_out_pin_out)
    else $error("pin released mid frame");
  rx_release_a: assert property (acc_w && ((avs_address_in == `UCS_OFS_CTRL_TWO
    && !avs_writedata_in[2]) || (avs_address_in == `UCS_OFS_CTRL_ONE && avs_writedata_in[7]))
    |=> !serial_in_pin_owned_out)
    else $error("receive pin kept");
  irq_masked_a: assert property ($past(ie_h) == 4'h0 |-> !irq_out)
    else $error("interrupt while masked");
endmodule // ucs_props

bind ucs_core ucs_props u_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .serial_out_pin_in(serial_out_pin_in),
  .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out),
  .serial_in_pin_in(serial_in_pin_in), .serial_in_pin_owned_out(serial_in_pin_owned_out),
  .irq_out(irq_out));

// >>> tb/ucs_node.sv
/* Remote serial node: sends 8N1 frames and decodes what it hears.
   Assumes an idle-high line; a frame with a low stop sample is a break. */
module ucs_node #(parameter int BT = 5) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out,
  output logic rep_stb_out,
  output logic [15:0] rep_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] f;
  logic [7:0] nl;
  int k;
  initial begin
    line_out = 1'b1;
    rep_stb_out = 1'b0;
    rep_out = 16'h0000;
  end
  // Mid-bit decoder; a break reports its low run so its length can be judged.
  always begin
    @(posedge clk_in);
    rep_stb_out <= 1'b0;
    if (!line_in) begin
      nl = 8'h00;
      repeat (BT / 2) @(posedge clk_in);
      for (k = 0; k < 10; k++) begin
        if (k > 0) repeat (BT) @(posedge clk_in);
        f[k] = line_in;
        nl = nl + {7'h00, !line_in};
      end
      while (!line_in && nl < 8'h40) begin
        repeat (BT) @(posedge clk_in);
        nl = nl + {7'h00, !line_in};
      end
      rep_out <= f[9] ? {8'h00, f[8:1]} : {nl, 8'h00};
      rep_stb_out <= 1'b1;
    end
  end
  // Sends one frame, least significant bit first, then leaves the line high.
  task automatic send(input logic [7:0] b);
    logic [9:0] s;
    s = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= s[i];
      repeat (BT) @(posedge clk_in);
    end
  endtask
endmodule // ucs_node

// >>> tb/tb_top.sv
/* Self-checking bench for the serial control block.
   Assumes the register map header and a pull-up on the transmit line. */
`include "ucs_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 5; // Bit time in clocks once the divisor is 4.
  logic clk_sys_in;
  logic nrst_in;
  logic [7:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, serial_out_pin_out, serial_out_pin_oe_out;
  wire serial_in_pin_in, serial_in_pin_owned_out, irq_out, rep_stb;
  wire [15:0] rep;
  wire tx_line = serial_out_pin_oe_out ? serial_out_pin_out : 1'b1; // Pull-up when released.
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] q_rd[$];
  logic [15:0] q_tx[$];
  always #25 clk_sys_in = ~clk_sys_in;
  ucs_core u_ucs_core (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .serial_out_pin_in(tx_line),
    .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out),
    .serial_in_pin_in(serial_in_pin_in), .serial_in_pin_owned_out(serial_in_pin_owned_out),
    .irq_out(irq_out));
  ucs_node #(.BT(BT)) u_ucs_node (.clk_in(clk_sys_in), .line_in(tx_line),
    .line_out(serial_in_pin_in), .rep_stb_out(rep_stb), .rep_out(rep));
  task automatic note(string w, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cmp_rd(logic [31:0] e, logic [31:0] s); note("readdata", e, s); endtask
  task automatic cmp_tx(logic [15:0] e, logic [15:0] s); note("frame", e, s); endtask
  task automatic cmp_pin(string w, logic e, logic s); note(w, e, s); endtask
  task automatic summarize();
    n_mismatch += q_rd.size() + q_tx.size();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out && n < 50);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d); bus(a, 1'b1, {16'h0000, d}); endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q_rd.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic tick(int n); repeat (n) @(posedge clk_sys_in); endtask
  // Result watchers take the oldest expectation off each queue.
  always @(posedge clk_sys_in) begin
    if (avs_read_in && !avs_waitrequest_out)
      cmp_rd(q_rd.size() ? q_rd.pop_front() : 'x, avs_readdata_out);
    if (rep_stb === 1'b1)
      cmp_tx(q_tx.size() ? q_tx.pop_front() : 'x, rep);
  end
  // Watchdog, so that a hung handshake still reaches the report.
  initial begin
    tick(100000);
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [7:0] v;
    clk_sys_in = 1'b0;
    nrst_in <= 1'b0;
    avs_address_in <= 8'h00;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    avs_writedata_in <= 32'h0;
    v = 8'($urandom(5));
    tick(10);
    nrst_in <= 1'b1;
    rd(`UCS_OFS_CTRL_TWO, 32'h0);
    rd(`UCS_OFS_STATUS_ONE, 32'hC0);
    rd(`UCS_OFS_BIT_DIV, 32'hAD);
    rd(8'h1C, 32'h0);
    wr(`UCS_OFS_STATUS_ONE, 16'h0000);
    rd(`UCS_OFS_STATUS_ONE, 32'hC0);
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 8'h80 >> i : 8'($urandom) & 8'hF0;
      wr(`UCS_OFS_CTRL_TWO, {8'h00, v});
      rd(`UCS_OFS_CTRL_TWO, {24'h0, v});
      tick(2);
      cmp_pin("irq", v[7] | v[6], irq_out);
    end
    wr(`UCS_OFS_BIT_DIV, 16'h0004);
    tick(180); // The count under the old divisor must run out first.
    wr(`UCS_OFS_CTRL_TWO, 16'h0008);
    tick(1);
    cmp_pin("tx_oe", 1'b1, serial_out_pin_oe_out);
    q_tx.push_back(16'h00A5);
    wr(`UCS_OFS_DATA, 16'h00A5);
    tick(2 * BT);
    rd(`UCS_OFS_STATUS_ONE, 32'h80);
    q_tx.push_back(16'h003C);
    wr(`UCS_OFS_DATA, 16'h003C);
    tick(25 * BT);
    q_tx.push_back(16'h0A00);
    wr(`UCS_OFS_CTRL_TWO, 16'h0009);
    wr(`UCS_OFS_CTRL_TWO, 16'h0008);
    tick(15 * BT);
    wr(`UCS_OFS_CTRL_ONE, 16'h0001);
    q_tx.push_back(16'h0D00);
    wr(`UCS_OFS_CTRL_TWO, 16'h0009);
    wr(`UCS_OFS_CTRL_TWO, 16'h0008);
    tick(20 * BT);
    wr(`UCS_OFS_CTRL_ONE, 16'h0000);
    rd(`UCS_OFS_STATUS_ONE, 32'hC0);
    v = 8'($urandom);
    q_tx.push_back({8'h00, v});
    wr(`UCS_OFS_DATA, {8'h00, v});
    wr(`UCS_OFS_CTRL_TWO, 16'h0000);
    wr(`UCS_OFS_CTRL_TWO, 16'h0008);
    tick(15 * BT);
    rd(`UCS_OFS_STATUS_ONE, 32'h80);
    tick(10 * BT);
    rd(`UCS_OFS_STATUS_ONE, 32'hC0);
    q_tx.push_back(16'h005A);
    wr(`UCS_OFS_DATA, 16'h005A);
    wr(`UCS_OFS_CTRL_TWO, 16'h0000);
    tick(2);
    cmp_pin("tx_oe", 1'b1, serial_out_pin_oe_out);
    tick(12 * BT);
    cmp_pin("tx_oe", 1'b0, serial_out_pin_oe_out);
    wr(`UCS_OFS_CTRL_TWO, 16'h0034);
    tick(1);
    cmp_pin("rx_own", 1'b1, serial_in_pin_owned_out);
    v = 8'($urandom);
    u_ucs_node.send(v);
    tick(3 * BT);
    cmp_pin("irq", 1'b1, irq_out);
    tick(12 * BT);
    rd(`UCS_OFS_STATUS_ONE, 32'hF0);
    rd(`UCS_OFS_DATA, {24'h0, v});
    tick(2);
    cmp_pin("irq", 1'b0, irq_out);
    tick(15 * BT);
    rd(`UCS_OFS_STATUS_ONE, 32'hC0);
    wr(`UCS_OFS_CTRL_ONE, 16'h0008);
    wr(`UCS_OFS_CTRL_TWO, 16'h0006);
    u_ucs_node.send(8'h12);
    tick(3 * BT);
    rd(`UCS_OFS_CTRL_TWO, 32'h06);
    u_ucs_node.send(8'h81);
    tick(3 * BT);
    rd(`UCS_OFS_CTRL_TWO, 32'h04);
    rd(`UCS_OFS_DATA, 32'h81);
    wr(`UCS_OFS_CTRL_ONE, 16'h0080);
    tick(1);
    cmp_pin("rx_own", 1'b0, serial_in_pin_owned_out);
    wr(`UCS_OFS_CTRL_TWO, 16'h0008);
    wr(`UCS_OFS_CTRL_ONE, 16'h00A0);
    tick(1);
    cmp_pin("tx_oe", 1'b0, serial_out_pin_oe_out);
    wr(`UCS_OFS_CTRL_ONE, 16'h00A2);
    tick(1);
    cmp_pin("tx_oe", 1'b1, serial_out_pin_oe_out);
    tick(10);
    summarize();
  end
endmodule // tb_top
